//--- hdl/ftcan_ctl.sv
// Control logic of the fault-tolerant low-speed CAN transceiver.
`include "ftcan_consts.svh"

module ftcan_ctl
  import ftcan_pkg::*;
#(
  parameter int unsigned DomTimeoutCyc = `FTCAN_DOM_TIMEOUT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        txIn,
  input  wire logic        txUndriven,
  input  wire logic        modeSelLowPowerN,
  input  wire logic        modeEnable,
  input  wire logic        wakePin,
  input  wire logic        vddLow,
  input  wire logic        busDominant,
  input  wire logic        busLowWake,
  input  wire logic [7:0]  wireFault,
  input  wire logic [1:0]  tempTrip,
  input  wire logic [1:0]  tempCool,
  output logic             busHighDrvOn,
  output logic             busLowDrvOn,
  output logic             termHighSwOn,
  output logic             termLowSwOn,
  output logic             termLowToBat,
  output logic             rxOut,
  output logic             faultFlagOutN,
  output logic             regulatorControlOut
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // True in the modes where the bus wake monitors run.
  function automatic logic isLowPwr(input ftcan_mode_e m);
    return (m == FTCAN_STANDBY) || (m == FTCAN_SLEEP) || (m == FTCAN_GOSLEEP);
  endfunction : isLowPwr

  // True for an address that holds a register.
  function automatic logic addrHit(input logic [7:0] a);
    return (a == `FTCAN_ADDR_CTRL) || (a == `FTCAN_ADDR_STAT);
  endfunction : addrHit

  // ----------------------------------------------------------------
  // Input synchronisation and filters
  // ----------------------------------------------------------------
  ftcan_pins_s pinsRaw, pins;
  ftcan_mode_e mode_r, mode_nxt;
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic        refOk_r, refOk_nxt, wakeRef_r, wakeRef_nxt;
  logic        domTo, wakeLocHit, wakeBusHit, wakeEv;

  // The internal pull-up makes a floating transmit input read high.
  always_comb begin
    pinsRaw.tx      = txIn | txUndriven;
    pinsRaw.lowPwrN = modeSelLowPowerN;
    pinsRaw.en      = modeEnable;
    pinsRaw.wake    = wakePin;
  end

  // All pin inputs cross two flops before use.
  ftcan_sync #(
    .RST (4'h8)
  ) uSync (
    .mclk  (mclk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .d     (pinsRaw),
    .q     (pins)
  );

  // Dominant timeout on a transmit input held low.
  ftcan_filter #(
    .CNT (DomTimeoutCyc)
  ) uDomTo (
    .mclk  (mclk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .lvl   (!pins.tx && ctrl_r[`FTCAN_CTRL_TOUT_EN]),
    .hit   (domTo)
  );

  // Local wake: wake pin differs from the stored reference.
  ftcan_filter #(
    .CNT (`FTCAN_WAKE_FILT_CYC)
  ) uWakeLoc (
    .mclk  (mclk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .lvl   (isLowPwr(mode_r) && refOk_r && (pins.wake != wakeRef_r)),
    .hit   (wakeLocHit)
  );

  // Remote wake: low bus line pulled below its wake threshold.
  ftcan_filter #(
    .CNT (`FTCAN_WAKE_FILT_CYC)
  ) uWakeBus (
    .mclk  (mclk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .lvl   (isLowPwr(mode_r) && busLowWake),
    .hit   (wakeBusHit)
  );

  assign wakeEv = wakeLocHit | wakeBusHit;
  // ----------------------------------------------------------------
  // Mode control and flags
  // ----------------------------------------------------------------
  logic       wake_r, wake_nxt, pwrOn_r, pwrOn_nxt;
  logic [1:0] hot_r, hot_nxt;
  logic       enterNormal;

  // Mode from the select pair; undervoltage overrides everything.
  always_comb begin
    mode_nxt = mode_r;
    if (clkEn) begin
      unique case ({pins.lowPwrN, pins.en})
        2'b11: mode_nxt = FTCAN_NORMAL;
        2'b10: mode_nxt = FTCAN_RXONLY;
        2'b01: mode_nxt = FTCAN_GOSLEEP;
        2'b00: begin
          if ((mode_r == FTCAN_GOSLEEP) || (mode_r == FTCAN_SLEEP)) begin
            mode_nxt = wakeEv ? FTCAN_STANDBY : FTCAN_SLEEP;
          end else begin
            mode_nxt = FTCAN_STANDBY;
          end
        end
      endcase
      if (vddLow) begin
        mode_nxt = FTCAN_STANDBY;
      end
    end
  end

  assign enterNormal = (mode_nxt == FTCAN_NORMAL) && (mode_r != FTCAN_NORMAL);
  // Wake reference, wake latch, power-on flag and thermal flags.
  always_comb begin
    refOk_nxt   = refOk_r;
    wakeRef_nxt = wakeRef_r;
    wake_nxt    = wake_r;
    pwrOn_nxt   = pwrOn_r;
    hot_nxt     = hot_r;
    if (clkEn) begin
      refOk_nxt = isLowPwr(mode_nxt);
      if (isLowPwr(mode_nxt) && !(isLowPwr(mode_r) && refOk_r)) begin
        wakeRef_nxt = pins.wake;
      end
      // A filter hit that lingers after leaving low power must not re-arm the latch.
      wake_nxt  = (wakeEv && isLowPwr(mode_r) && !wake_r) || (wake_r && !enterNormal);
      pwrOn_nxt = pwrOn_r && !enterNormal;
      for (int i = 0; i < 2; i++) begin
        hot_nxt[i] = tempTrip[i] || (hot_r[i] && !tempCool[i]);
      end
    end
  end

  // State registers; the power-on flag starts set.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_r    <= FTCAN_STANDBY;
      refOk_r   <= 1'b0;
      wakeRef_r <= 1'b0;
      wake_r    <= 1'b0;
      pwrOn_r   <= 1'b1;
      hot_r     <= 2'h0;
    end else begin
      mode_r    <= mode_nxt;
      refOk_r   <= refOk_nxt;
      wakeRef_r <= wakeRef_nxt;
      wake_r    <= wake_nxt;
      pwrOn_r   <= pwrOn_nxt;
      hot_r     <= hot_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bus drivers, switches and pin outputs
  // ----------------------------------------------------------------
  logic hiDrv_r, hiDrv_nxt, loDrv_r, loDrv_nxt;
  logic hiTerm_r, hiTerm_nxt, loTerm_r, loTerm_nxt, toBat_r, toBat_nxt;
  logic rx_r, rx_nxt, errN_r, errN_nxt, reg_r, reg_nxt;
  logic active, txDom, hiOff, loOff;

  // Output next values from mode, transmit level and faults.
  always_comb begin
    active = (mode_r == FTCAN_NORMAL) || (mode_r == FTCAN_RXONLY);
    txDom  = (mode_r == FTCAN_NORMAL) && !pins.tx && !domTo;
    hiOff  = ctrl_r[`FTCAN_CTRL_FAULT_SW_EN] && |(wireFault & `FTCAN_HIGH_FAULT_MASK);
    loOff  = ctrl_r[`FTCAN_CTRL_FAULT_SW_EN] && |(wireFault & `FTCAN_LOW_FAULT_MASK);
    hiDrv_nxt  = hiDrv_r;
    loDrv_nxt  = loDrv_r;
    hiTerm_nxt = hiTerm_r;
    loTerm_nxt = loTerm_r;
    toBat_nxt  = toBat_r;
    rx_nxt     = rx_r;
    errN_nxt   = errN_r;
    reg_nxt    = reg_r;
    if (clkEn) begin
      hiDrv_nxt  = txDom && !hot_r[0] && !hiOff;
      loDrv_nxt  = txDom && !hot_r[1] && !loOff;
      hiTerm_nxt = active && !hiOff;
      loTerm_nxt = active && !loOff;
      toBat_nxt  = isLowPwr(mode_r) && !loOff;
      rx_nxt     = active ? !busDominant : !wake_r;
      unique case (mode_r)
        FTCAN_NORMAL: errN_nxt = !(|wireFault);
        FTCAN_RXONLY: errN_nxt = !pwrOn_r;
        default:      errN_nxt = !wake_r;
      endcase
      reg_nxt = (mode_r != FTCAN_SLEEP) && (mode_r != FTCAN_GOSLEEP);
    end
  end

  // Output registers; reset leaves the device in standby.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hiDrv_r  <= 1'b0;
      loDrv_r  <= 1'b0;
      hiTerm_r <= 1'b0;
      loTerm_r <= 1'b0;
      toBat_r  <= 1'b1;
      rx_r     <= 1'b1;
      errN_r   <= 1'b1;
      reg_r    <= 1'b1;
    end else begin
      hiDrv_r  <= hiDrv_nxt;
      loDrv_r  <= loDrv_nxt;
      hiTerm_r <= hiTerm_nxt;
      loTerm_r <= loTerm_nxt;
      toBat_r  <= toBat_nxt;
      rx_r     <= rx_nxt;
      errN_r   <= errN_nxt;
      reg_r    <= reg_nxt;
    end
  end

  assign busHighDrvOn        = hiDrv_r;
  assign busLowDrvOn         = loDrv_r;
  assign termHighSwOn        = hiTerm_r;
  assign termLowSwOn         = loTerm_r;
  assign termLowToBat        = toBat_r;
  assign rxOut               = rx_r;
  assign faultFlagOutN       = errN_r;
  assign regulatorControlOut = reg_r;

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  ftcan_stat_s stat;

  // Live status snapshot.
  always_comb begin
    stat.fault = wireFault;
    stat.hot   = hot_r;
    stat.domTo = domTo;
    stat.pwrOn = pwrOn_r;
    stat.wake  = wake_r;
    stat.mode  = mode_r;
  end

  // One wait state: ready rises one cycle into the access phase.
  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = pready_r;
    pslverr_nxt = pslverr_r;
    ctrl_nxt    = ctrl_r;
    if (clkEn) begin
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      if (psel && penable && !pready_r) begin
        pready_nxt  = 1'b1;
        pslverr_nxt = !addrHit(paddr);
        prdata_nxt  = 32'h0;
        if (!pwrite && (paddr == `FTCAN_ADDR_CTRL)) begin
          prdata_nxt = {30'h0, ctrl_r};
        end else if (!pwrite && (paddr == `FTCAN_ADDR_STAT)) begin
          prdata_nxt = {16'h0, stat};
        end
      end
      if (psel && penable && pready_r && pwrite && (paddr == `FTCAN_ADDR_CTRL)) begin
        ctrl_nxt = pwdata[1:0];
      end
    end
  end

  // Bus registers.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r    <= `FTCAN_CTRL_RST;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

endmodule : ftcan_ctl

//--- hdl/ftcan_filter.sv
// Persistence filter: flags a level that has held for more than CNT cycles.
module ftcan_filter #(
  parameter int unsigned CNT = 400
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic clkEn,
  input  wire logic lvl,
  output logic      hit
);

  localparam int W = $clog2(CNT + 1);

  logic [W-1:0] cnt_r, cnt_nxt;
  logic         hit_r, hit_nxt;

  // Count while the level holds; any drop restarts the count.
  always_comb begin
    cnt_nxt = cnt_r;
    hit_nxt = hit_r;
    if (clkEn) begin
      if (!lvl) begin
        cnt_nxt = '0;
        hit_nxt = 1'b0;
      end else if (cnt_r == W'(CNT)) begin
        hit_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  // Counter and flag registers.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      hit_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign hit = hit_r;

endmodule : ftcan_filter

//--- hdl/ftcan_sync.sv
// Two-flop synchroniser for the pin input bundle.
module ftcan_sync
  import ftcan_pkg::*;
#(
  parameter ftcan_pins_s RST = 4'h8
) (
  input  wire logic  mclk,
  input  wire logic  rstn,
  input  wire logic  clkEn,
  input  ftcan_pins_s d,
  output ftcan_pins_s q
);

  ftcan_pins_s s1_r, s1_nxt, s2_r, s2_nxt;

  // Next values; the first stage feeds only the second.
  always_comb begin
    s1_nxt = clkEn ? d : s1_r;
    s2_nxt = clkEn ? s1_r : s2_r;
  end

  // Stage registers.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= RST;
      s2_r <= RST;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q = s2_r;

endmodule : ftcan_sync

//--- include/ftcan_consts.svh
// Constant definitions for the fault-tolerant CAN transceiver control block.
`ifndef FTCAN_CONSTS_SVH
`define FTCAN_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FTCAN_CLK_PERIOD_NS    20
`define FTCAN_WAKE_FILT_MIN_NS 8000
`define FTCAN_WAKE_FILT_MAX_NS 38000
`define FTCAN_WAKE_FILT_CYC \
  ((`FTCAN_WAKE_FILT_MIN_NS + `FTCAN_CLK_PERIOD_NS - 1) / `FTCAN_CLK_PERIOD_NS)
`define FTCAN_DOM_TIMEOUT_NS   2000000
`define FTCAN_DOM_TIMEOUT_CYC  (`FTCAN_DOM_TIMEOUT_NS / `FTCAN_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FTCAN_ADDR_CTRL        8'h00
`define FTCAN_ADDR_STAT        8'h04
`define FTCAN_CTRL_TOUT_EN     0
`define FTCAN_CTRL_FAULT_SW_EN 1
`define FTCAN_CTRL_RST         2'h3
`define FTCAN_STAT_MODE_LSB    0
`define FTCAN_STAT_WAKE        3
`define FTCAN_STAT_PWRON       4
`define FTCAN_STAT_DOMTO       5
`define FTCAN_STAT_HOT_LSB     6
`define FTCAN_STAT_FAULT_LSB   8

// ----------------------------------------------------------------
// Wiring failure groups (bit n is failure n+1)
// ----------------------------------------------------------------
`define FTCAN_HIGH_FAULT_MASK  8'h84
`define FTCAN_LOW_FAULT_MASK   8'h68

`endif

//--- include/ftcan_pkg.sv
// Types shared by the fault-tolerant CAN transceiver control block.
package ftcan_pkg;

  // Operating modes, Gray coded along standby-normal-rxonly-gotosleep-sleep.
  typedef enum logic [2:0] {
    FTCAN_STANDBY = 3'h0,
    FTCAN_NORMAL  = 3'h1,
    FTCAN_RXONLY  = 3'h3,
    FTCAN_GOSLEEP = 3'h2,
    FTCAN_SLEEP   = 3'h6
  } ftcan_mode_e;

  // Pin inputs that pass the synchroniser together.
  typedef struct packed {
    logic tx;
    logic lowPwrN;
    logic en;
    logic wake;
  } ftcan_pins_s;

  // Status word, laid out from the top bit down to bit 0.
  typedef struct packed {
    logic [7:0]  fault;
    logic [1:0]  hot;
    logic        domTo;
    logic        pwrOn;
    logic        wake;
    ftcan_mode_e mode;
  } ftcan_stat_s;

endpackage : ftcan_pkg

//--- verification/ftcan_ctl_chk.sv
// Concurrent checks on the pins of the transceiver control block.
module ftcan_ctl_chk #(
  parameter int unsigned DomTimeoutCyc = 100000
) (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       txIn,
  input wire logic       busDominant,
  input wire logic [7:0] wireFault,
  input wire logic [1:0] tempTrip,
  input wire logic       busHighDrvOn,
  input wire logic       busLowDrvOn,
  input wire logic       termHighSwOn,
  input wire logic       termLowToBat,
  input wire logic       rxOut,
  input wire logic       faultFlagOutN,
  input wire logic       regulatorControlOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] domCnt_r;
  logic [31:0] domCnt_nxt;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Length of the current run of cycles with the high driver on.
  always_comb begin
    domCnt_nxt = busHighDrvOn ? domCnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      domCnt_r <= 32'h0;
    end else begin
      domCnt_r <= domCnt_nxt;
    end
  end

  // A started access phase is answered after one wait state.
  AST_APB_WAIT: assert property (
    psel && penable && !pready |=> pready)
    else $error("access phase not answered in time");
  // A driver is on only three edges after a low transmit level.
  AST_DRV_TX: assert property (
    (busHighDrvOn || busLowDrvOn) |-> !$past(txIn, 3))
    else $error("driver on without a transmit request");
  // With the high driver on, a dominant bus shows as a low receive output one edge later.
  AST_RX_DOM: assert property (
    busHighDrvOn && busDominant |=> !rxOut)
    else $error("receive output not low on dominant bus");
  // A wiring failure while the high driver is on pulls the error output low.
  AST_FAULT: assert property (
    busHighDrvOn && (wireFault != 8'h00) |=> !faultFlagOutN)
    else $error("error output high during wiring failure");
  // Battery bias of the low line only with both drivers off.
  AST_LOWPWR: assert property (
    termLowToBat |-> !(busHighDrvOn || busLowDrvOn))
    else $error("driver on in low power mode");
  // The regulator is released only in a low power mode.
  AST_REG: assert property (
    !regulatorControlOut |-> termLowToBat || ($past(wireFault) != 8'h00))
    else $error("regulator released outside low power");
  // A stuck dominant transmit is cut off after the timeout.
  AST_DOMTO: assert property (
    busHighDrvOn |-> domCnt_r <= DomTimeoutCyc + 2)
    else $error("dominant timeout not enforced");
  // An overheated low driver is switched off.
  AST_TEMP: assert property (
    tempTrip[1] [*4] |-> !busLowDrvOn)
    else $error("hot low driver still on");
  // A high line short to battery opens its termination switch.
  AST_TERM: assert property (
    wireFault[2] [*3] |-> !termHighSwOn)
    else $error("termination switch closed during fault");

  // Main scenarios reached.
  COV_DOM: cover property (busHighDrvOn && busLowDrvOn);
  COV_ERR: cover property (!faultFlagOutN);
  COV_SLEEP: cover property (!regulatorControlOut);
  COV_APB: cover property (pready);
endmodule : ftcan_ctl_chk

//--- verification/ftcan_mcu_model.sv
// Controller side model that drives the transmit and mode-select pins.
module ftcan_mcu_model (
  input  wire logic       mclk,
  input  wire logic       domReq,
  input  wire logic [1:0] modeReq,
  output logic            txIn,
  output logic            modeSelLowPowerN,
  output logic            modeEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins start recessive with both selects low, as after power-up.
  initial begin
    txIn = 1'b1;
    modeSelLowPowerN = 1'b0;
    modeEnable = 1'b0;
  end
  // Pins change just after the clock edge, as port writes would.
  always @(posedge mclk) begin
    txIn <= !domReq;
    modeSelLowPowerN <= modeReq[1];
    modeEnable <= modeReq[0];
  end
endmodule : ftcan_mcu_model

//--- verification/tb_ftcan_ctl.sv
// Self-checking testbench for the transceiver control block.
module tb_ftcan_ctl
  import ftcan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DomTimeoutCyc = 100;
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, wireFault;
  logic [31:0] pwdata, prdata, rdat;
  logic        txIn, txUndriven, modeSelLowPowerN, modeEnable, wakePin, vddLow;
  logic        busDominant, busLowWake, domReq, otherDom, rxOut, faultFlagOutN;
  logic        busHighDrvOn, busLowDrvOn, termHighSwOn, termLowSwOn, termLowToBat;
  logic        regulatorControlOut, clkEn;
  logic [1:0]  modeReq, tempTrip, tempCool;
  int          errors, checks_done;

  // The bus is dominant when our drivers or another node pull it.
  assign busDominant = busHighDrvOn | busLowDrvOn | otherDom;

  ftcan_mcu_model mcu (.mclk, .domReq, .modeReq, .txIn, .modeSelLowPowerN, .modeEnable);
  ftcan_ctl #(.DomTimeoutCyc(DomTimeoutCyc)) dut (
    .mclk, .rstn, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .txIn, .txUndriven, .modeSelLowPowerN, .modeEnable, .wakePin,
    .vddLow, .busDominant, .busLowWake, .wireFault, .tempTrip, .tempCool, .busHighDrvOn,
    .busLowDrvOn, .termHighSwOn, .termLowSwOn, .termLowToBat, .rxOut, .faultFlagOutN,
    .regulatorControlOut);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task setMode(input logic [1:0] m);
    @(posedge mclk);
    modeReq <= m;
    cyc(8);
  endtask : setMode

  task tRegs;
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h3);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[4:0], 5'h10);
    apb(1'b0, 8'h08, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    apb(1'b1, 8'h00, 32'hffffffff);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h3);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, 8'h00, 32'h3);
    setMode(2'b10);
    @(negedge mclk);
    chk(faultFlagOutN, 1'b0);
    chk(regulatorControlOut, 1'b1);
  endtask : tRegs

  task tNormal;
    setMode(2'b11);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[4:0], 5'h01);
    chk({faultFlagOutN, termHighSwOn, termLowSwOn}, 3'h7);
    domReq <= 1'b1;
    cyc(5);
    @(negedge mclk);
    chk({busHighDrvOn, busLowDrvOn, rxOut}, 3'h6);
    cyc(1);
    wireFault <= 8'h01;
    cyc(2);
    @(negedge mclk);
    chk(faultFlagOutN, 1'b0);
    cyc(1);
    wireFault <= 8'h04;
    cyc(3);
    @(negedge mclk);
    chk({termHighSwOn, busHighDrvOn, busLowDrvOn}, 3'h1);
    cyc(1);
    wireFault <= 8'h00;
    tempTrip <= 2'b10;
    cyc(4);
    @(negedge mclk);
    chk({faultFlagOutN, busLowDrvOn}, 2'h2);
    cyc(1);
    tempTrip <= 2'b00;
    cyc(4);
    @(negedge mclk);
    chk(busLowDrvOn, 1'b0);
    cyc(1);
    tempCool <= 2'b10;
    cyc(4);
    @(negedge mclk);
    chk(busLowDrvOn, 1'b1);
    cyc(1);
    tempCool <= 2'b00;
    txUndriven <= 1'b1;
    cyc(5);
    @(negedge mclk);
    chk({busHighDrvOn, busLowDrvOn}, 2'h0);
    cyc(1);
    txUndriven <= 1'b0;
    domReq <= 1'b0;
    otherDom <= 1'b1;
    cyc(4);
    @(negedge mclk);
    chk(rxOut, 1'b0);
    cyc(1);
    otherDom <= 1'b0;
  endtask : tNormal

  task tDomTimeout;
    domReq <= 1'b1;
    cyc(95);
    @(negedge mclk);
    chk(busHighDrvOn, 1'b1);
    cyc(20);
    @(negedge mclk);
    chk({busHighDrvOn, busLowDrvOn}, 2'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[5], 1'b1);
    domReq <= 1'b0;
    cyc(5);
  endtask : tDomTimeout

  task tWake;
    setMode(2'b00);
    wakePin <= 1'b1;
    cyc(300);
    @(negedge mclk);
    chk(rxOut, 1'b1);
    cyc(120);
    @(negedge mclk);
    chk({rxOut, faultFlagOutN}, 2'h0);
    setMode(2'b11);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[3], 1'b0);
  endtask : tWake

  task tSleep;
    setMode(2'b01);
    setMode(2'b00);
    @(negedge mclk);
    chk({regulatorControlOut, termLowToBat}, 2'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[2:0], 3'h6);
    busLowWake <= 1'b1;
    cyc(420);
    @(negedge mclk);
    chk({regulatorControlOut, rxOut}, 2'h2);
    cyc(1);
    busLowWake <= 1'b0;
    setMode(2'b11);
  endtask : tSleep

  task tUndervoltage;
    vddLow <= 1'b1;
    cyc(6);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat[2:0], 3'h0);
    vddLow <= 1'b0;
    cyc(8);
  endtask : tUndervoltage

  // A low clock enable freezes the block, so a dominant request waits for it.
  task tClkEn;
    clkEn <= 1'b0;
    domReq <= 1'b1;
    cyc(8);
    @(negedge mclk);
    chk({busHighDrvOn, busLowDrvOn}, 2'h0);
    cyc(1);
    clkEn <= 1'b1;
    cyc(5);
    @(negedge mclk);
    chk({busHighDrvOn, busLowDrvOn}, 2'h3);
    cyc(1);
    domReq <= 1'b0;
    cyc(5);
  endtask : tClkEn

  task results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Reset for 20 cycles, then the scenarios in order.
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, txUndriven, wakePin} = '0;
    {vddLow, busLowWake, domReq, otherDom, modeReq, tempTrip, tempCool} = '0;
    wireFault = 8'h00;
    clkEn = 1'b1;
    errors = 0;
    checks_done = 0;
    cyc(20);
    rstn <= 1'b1;
    cyc(2);
    tRegs();
    tNormal();
    tDomTimeout();
    tWake();
    tSleep();
    tUndervoltage();
    tClkEn();
    results();
  end

  // A hang past the expected run length counts as a mismatch.
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule : tb_ftcan_ctl

bind ftcan_ctl ftcan_ctl_chk #(.DomTimeoutCyc(DomTimeoutCyc)) chk (
  .mclk, .rstn, .psel, .penable, .pready, .txIn, .busDominant, .wireFault, .tempTrip,
  .busHighDrvOn, .busLowDrvOn, .termHighSwOn, .termLowToBat, .rxOut, .faultFlagOutN,
  .regulatorControlOut);
